//--- mcis_cfg.svh
// Register offsets, reset values and timing figures of the monitor control block
`ifndef MCIS_CFG_SVH
`define MCIS_CFG_SVH

`define MCIS_ADDR_CFG 8'h40
`define MCIS_ADDR_STAT1 8'h41
`define MCIS_ADDR_STAT2 8'h42
`define MCIS_ADDR_MASK1 8'h43

`define MCIS_CFG_RESET 8'h08
`define MCIS_STAT_RESET 8'h00
`define MCIS_MASK_RESET 8'h00
`define MCIS_READ_NONE 8'h00

`define MCIS_BIT_RUN 0
`define MCIS_BIT_IRQ_EN 1
`define MCIS_BIT_OVT_EN 2
`define MCIS_BIT_IRQ_CLR 3
`define MCIS_BIT_RST_REQ 4
`define MCIS_BIT_OVT_CLR 6
`define MCIS_BIT_INIT 7

`define MCIS_S1_TEMP_INT 4
`define MCIS_S1_TEMP_REM 5
`define MCIS_S2_CHASSIS 4
`define MCIS_S2_OVT_PIN 5

`define MCIS_CLK_MHZ 100
`define MCIS_RST_PULSE_MS 45
`define MCIS_US_PER_MS 1000
`define MCIS_RST_PULSE_CYC (`MCIS_RST_PULSE_MS * `MCIS_US_PER_MS * `MCIS_CLK_MHZ)
`define MCIS_RST_CNT_W 23
`define MCIS_RST_CNT_ZERO 23'h00_0000

`endif

//--- mcis_host_model.sv
// Register host model driving the monitor's register port
`timescale 1ns/100ps
module mcis_host_model (
    input wire logic core_clk, // System clock
    output logic [7:0] regAddr, // Register offset
    output logic regWr, // Write strobe
    output logic regRd, // Read strobe
    output logic [7:0] regWrData, // Write data
    input wire logic [7:0] regRdData // Read data
);
    logic [7:0] rdData;
    event rdEv;
    initial begin
        regAddr = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        regWrData = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        regAddr = a;
        regWrData = d;
        regWr = 1'b1;
        @(negedge core_clk);
        regWr = 1'b0;
        // Released data inverted so a stale value is never mistaken for a write
        regWrData = ~d;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge core_clk);
        regAddr = a;
        regRd = 1'b1;
        @(negedge core_clk);
        regRd = 1'b0;
        regAddr = ~a;
        @(negedge core_clk);
        rdData = regRdData;
        ->rdEv;
    endtask
endmodule

//--- mcis_pkg.sv
// Types shared by the monitor control block
package mcis_pkg;

    typedef struct packed {
        logic initialize;
        logic ovtClear;
        logic reserved5;
        logic resetReq;
        logic irqClear;
        logic ovtEnable;
        logic irqEnable;
        logic run;
    } mcis_cfg_t;

    typedef struct packed {
        logic [7:0] limit1;
        logic [1:0] tempEvt;
        logic [1:0] limit2;
        logic [1:0] diodeFault;
    } mcis_events_t;

    typedef struct packed {
        logic active;
        logic [22:0] count;
    } mcis_timer_t;

    typedef struct packed {
        logic [7:0] bits;
    } mcis_stat_t;

    typedef struct packed {
        mcis_cfg_t cfg;
        logic [7:0] mask1;
        logic ovtLatched;
        logic ovtOe;
        logic monActive;
        logic irqOutN;
        logic resetOutN;
        logic [7:0] rdData;
    } mcis_top_t;

endpackage

//--- mcis_pulse_timer.sv
// One-shot low pulse timer for the reset output
`timescale 1ns/100ps
`include "mcis_cfg.svh"
module mcis_pulse_timer #(
    parameter int unsigned CYCLES = `MCIS_RST_PULSE_CYC
) (
    input wire logic core_clk, // System clock
    input wire logic rst_n, // Synchronous reset
    input wire logic start, // Request one pulse
    output logic busy // Pulse in progress
);
    mcis_pkg::mcis_timer_t st;
    mcis_pkg::mcis_timer_t next_st;

    always_comb begin
        next_st = st;
        if (st.active) begin
            if (st.count == `MCIS_RST_CNT_ZERO) begin
                next_st.active = 1'b0;
            end else begin
                next_st.count = st.count - 1'b1;
            end
        end else if (start) begin
            // Requests during a pulse are dropped, no retrigger
            next_st.active = 1'b1;
            next_st.count = `MCIS_RST_CNT_W'(CYCLES - 1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign busy = st.active;
endmodule

//--- mcis_sticky_status.sv
// Sticky clear-on-read status byte
`timescale 1ns/100ps
`include "mcis_cfg.svh"
module mcis_sticky_status (
    input wire logic core_clk, // System clock
    input wire logic rst_n, // Synchronous reset
    input wire logic [7:0] setVec, // Conditions present this cycle
    input wire logic readClr, // Byte is being read
    input wire logic init, // Restore default
    output logic [7:0] status // Current flags
);
    mcis_pkg::mcis_stat_t st;
    mcis_pkg::mcis_stat_t next_st;

    always_comb begin
        next_st = st;
        if (init) begin
            next_st.bits = `MCIS_STAT_RESET;
        end else if (readClr) begin
            // Only the bits returned by this read are dropped
            next_st.bits = st.bits & ~st.bits;
        end
        // A condition still present sets again, so set wins
        next_st.bits = next_st.bits | setVec; // R18
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st.bits <= `MCIS_STAT_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign status = st.bits;
endmodule

//--- mcis_top.sv
// Configuration, interrupt status and mask logic of the hardware monitor
// What this block does
// R1: Config bit 0 runs the monitor when 1, standby when 0; resets to 0.
// R2: Clearing the run bit leaves an asserted interrupt output asserted.
// R3: With run set and bit 3 clear, channel scanning and limit comparison are enabled.
// R4: Host should program all limits before setting the run bit.
// R5: Config bit 1 enables the interrupt output; default 0.
// R6: Config bit 3 high deasserts the interrupt output, status untouched.
// R7: Config bit 3 high suspends monitoring until cleared.
// R8: Writing bit 4 without bit 7 gives one 45 ms low reset pulse; bit self-clears.
// R9: Writing bit 6 deasserts the over-temperature output, status untouched.
// R10: Writing bit 7 restores defaults of config, status and mask; self-clears.
// R11: Status 1 bits 0-3,6,7 flag limit violations of their channels.
// R12: Status 1 bits 4,5 flag temperature events or limit violations.
// R13: Status 2 bits 0,1 flag 12 V and core_volt2; bits 2,3 reserved.
// R14: Status 2 bit 4 sets while chassis_open is high.
// R15: Status 2 bit 5 sets when overtemp_n is pulled low externally.
// R16: Status 2 bits 6,7 flag remote diode 1 and 2 faults.
// R17: Reading a status register clears the bits that read returned.
// R18: A condition still present raises its flag again after the read.
// R19: Mask 1 bit at 1 blocks the matching status 1 bit from interrupt.
// R20: irq_out_n low when enabled, not cleared, and any unmasked status set.
// R21: Config bit 2 enables the over-temperature output.
`timescale 1ns/100ps
`include "mcis_cfg.svh"
module mcis_top #(
    parameter int unsigned RST_PULSE_CYCLES = `MCIS_RST_PULSE_CYC
) (
    input wire logic core_clk, // System clock, 100 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [7:0] regAddr, // Register offset
    input wire logic regWr, // Write strobe
    input wire logic regRd, // Read strobe
    input wire logic [7:0] regWrData, // Write data
    output logic [7:0] regRdData, // Read data, valid cycle after strobe
    input wire mcis_pkg::mcis_events_t events, // Comparator and fault results
    input wire logic chassisOpen, // Chassis intrusion level
    input wire logic overtempEvent, // Temperature over its limit
    input wire logic overtempIn, // Level seen on overtemp_n pin
    output logic overtempOut, // Drive value of overtemp_n pin
    output logic overtempOe, // Drive enable of overtemp_n pin
    output logic irqOutN, // Interrupt output, active low
    output logic resetOutN, // Reset pulse output, active low
    output logic monitorActive // Scan and compare enable
);
    mcis_pkg::mcis_top_t st;
    mcis_pkg::mcis_top_t next_st;
    mcis_pkg::mcis_cfg_t wrCfg;
    logic [7:0] status1;
    logic [7:0] status2;
    logic [7:0] set1;
    logic [7:0] set2;
    logic wrCfgHit;
    logic rdStat1;
    logic rdStat2;
    logic doInit;
    logic pulseStart;
    logic pulseBusy;
    logic ovtExternal;
    logic irqPending;

    assign wrCfg = regWrData;
    assign wrCfgHit = regWr && (regAddr == `MCIS_ADDR_CFG);
    assign rdStat1 = regRd && (regAddr == `MCIS_ADDR_STAT1);
    assign rdStat2 = regRd && (regAddr == `MCIS_ADDR_STAT2);
    assign doInit = wrCfgHit && wrCfg.initialize; // R10
    assign pulseStart = wrCfgHit && wrCfg.resetReq && !wrCfg.initialize; // R8

    // Pin driven low only by us; anything else low is external
    assign ovtExternal = !overtempIn && !st.ovtOe; // R15

    always_comb begin
        set1 = `MCIS_STAT_RESET;
        set2 = `MCIS_STAT_RESET;
        if (st.monActive) begin
            set1 = events.limit1; // R11
            set1[`MCIS_S1_TEMP_INT] = events.limit1[`MCIS_S1_TEMP_INT] | events.tempEvt[0]; // R12
            set1[`MCIS_S1_TEMP_REM] = events.limit1[`MCIS_S1_TEMP_REM] | events.tempEvt[1]; // R12
            set2[1:0] = events.limit2; // R13
        end
        // Pin and fault detectors keep watching in standby
        set2[`MCIS_S2_CHASSIS] = chassisOpen; // R14
        set2[`MCIS_S2_OVT_PIN] = ovtExternal; // R15
        set2[7:6] = events.diodeFault; // R16
    end

    mcis_sticky_status u_stat1 (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .setVec(set1),
        .readClr(rdStat1), // R17
        .init(doInit),
        .status(status1)
    );

    mcis_sticky_status u_stat2 (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .setVec(set2),
        .readClr(rdStat2), // R17
        .init(doInit),
        .status(status2)
    );

    mcis_pulse_timer #(
        .CYCLES(RST_PULSE_CYCLES)
    ) u_rst_pulse (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(pulseStart),
        .busy(pulseBusy)
    );

    // Status 2 has no mask here, its bits always reach the interrupt
    assign irqPending = (|(status1 & ~st.mask1)) | (|status2); // R19

    always_comb begin
        next_st = st;
        if (doInit) begin
            next_st.cfg = `MCIS_CFG_RESET; // R10
            next_st.mask1 = `MCIS_MASK_RESET; // R10
        end else begin
            if (wrCfgHit) begin
                next_st.cfg = wrCfg;
                // Action bits are never stored
                next_st.cfg.resetReq = 1'b0; // R8
                next_st.cfg.ovtClear = 1'b0;
                next_st.cfg.initialize = 1'b0;
            end
            if (regWr && (regAddr == `MCIS_ADDR_MASK1)) begin
                next_st.mask1 = regWrData;
            end
        end
        // Clear by write, but a live event still latches
        if (wrCfgHit && wrCfg.ovtClear) begin
            next_st.ovtLatched = 1'b0; // R9
        end
        if (overtempEvent && st.cfg.ovtEnable) begin
            next_st.ovtLatched = 1'b1;
        end
        next_st.ovtOe = st.ovtLatched && st.cfg.ovtEnable && !(wrCfgHit && wrCfg.ovtClear); // R21
        next_st.monActive = next_st.cfg.run && !next_st.cfg.irqClear; // R1 R3 R7
        // Run bit plays no part, so standby keeps the line asserted
        next_st.irqOutN = !(st.cfg.irqEnable && !st.cfg.irqClear && irqPending); // R2 R5 R6 R20
        next_st.resetOutN = !pulseBusy; // R8
        next_st.rdData = st.rdData;
        if (regRd) begin
            unique case (regAddr)
                `MCIS_ADDR_CFG: begin
                    next_st.rdData = st.cfg;
                    next_st.rdData[`MCIS_BIT_RST_REQ] = pulseBusy;
                end
                `MCIS_ADDR_STAT1: begin
                    next_st.rdData = status1;
                end
                `MCIS_ADDR_STAT2: begin
                    next_st.rdData = status2;
                end
                `MCIS_ADDR_MASK1: begin
                    next_st.rdData = st.mask1;
                end
                default: begin
                    next_st.rdData = `MCIS_READ_NONE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st.cfg <= `MCIS_CFG_RESET;
            st.mask1 <= `MCIS_MASK_RESET;
            st.ovtLatched <= 1'b0;
            st.ovtOe <= 1'b0;
            st.monActive <= 1'b0;
            st.irqOutN <= 1'b1;
            st.resetOutN <= 1'b1;
            st.rdData <= `MCIS_READ_NONE;
        end else begin
            st <= next_st;
        end
    end

    assign regRdData = st.rdData;
    assign overtempOut = 1'b0;
    assign overtempOe = st.ovtOe;
    assign irqOutN = st.irqOutN;
    assign resetOutN = st.resetOutN;
    assign monitorActive = st.monActive;

    a_irq_level: assert property (@(posedge core_clk) disable iff (!rst_n) // R20
        !irqOutN |-> $past(st.cfg.irqEnable) && !$past(st.cfg.irqClear) && $past(irqPending))
        else $error("interrupt asserted without enabled pending cause");

    a_irq_cleared: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
        st.cfg.irqClear |=> irqOutN)
        else $error("interrupt asserted while clear bit set");

    a_irq_masked: assert property (@(posedge core_clk) disable iff (!rst_n) // R19
        (status2 == 8'h00 && (status1 & ~st.mask1) == 8'h00) |=> irqOutN)
        else $error("masked status drove the interrupt");

    a_run_keeps_irq: assert property (@(posedge core_clk) disable iff (!rst_n) // R2
        (wrCfgHit && !wrCfg.run && wrCfg.irqEnable && !wrCfg.irqClear && !wrCfg.initialize
         && st.cfg.irqEnable && !st.cfg.irqClear && irqPending && !rdStat1 && !rdStat2)
        |=> ##1 !irqOutN)
        else $error("stopping the monitor dropped the interrupt");

    a_monitor_gate: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
        monitorActive |-> st.cfg.run && !st.cfg.irqClear)
        else $error("monitoring while stopped or suspended");

    a_reset_pulse: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
        (pulseStart && !pulseBusy) |=> ##1 !resetOutN [*8])
        else $error("reset pulse missing or too short");

    a_read_clears: assert property (@(posedge core_clk) disable iff (!rst_n) // R17
        (rdStat1 && !doInit) |=> status1 == $past(set1))
        else $error("status read did not clear returned bits");

    a_init_defaults: assert property (@(posedge core_clk) disable iff (!rst_n) // R10
        doInit |=> (st.cfg == `MCIS_CFG_RESET) && (st.mask1 == `MCIS_MASK_RESET))
        else $error("initialize did not restore defaults");

    a_ovt_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // R9
        (wrCfgHit && wrCfg.ovtClear && !overtempEvent) |=> !st.ovtLatched ##1 !overtempOe)
        else $error("over-temperature output not cleared");

    a_chassis_flag: assert property (@(posedge core_clk) disable iff (!rst_n) // R14
        chassisOpen |=> status2[`MCIS_S2_CHASSIS])
        else $error("chassis intrusion not flagged");

    // Suspended or standby scanning must not add limit flags
    a_standby_quiet: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
        (!monitorActive && !rdStat1 && !doInit) |=> status1 == $past(status1))
        else $error("status 1 flag raised while not monitoring");

    a_irq_enable_gate: assert property (@(posedge core_clk) disable iff (!rst_n) // R5
        !st.cfg.irqEnable |=> irqOutN)
        else $error("interrupt asserted while output disabled");

    a_irq_raise: assert property (@(posedge core_clk) disable iff (!rst_n) // R20
        (st.cfg.irqEnable && !st.cfg.irqClear && irqPending) |=> !irqOutN)
        else $error("pending unmasked status did not assert interrupt");

    a_action_bits: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
        wrCfgHit |=> !st.cfg.resetReq && !st.cfg.ovtClear && !st.cfg.initialize)
        else $error("action bit stayed set after write");

    a_init_status: assert property (@(posedge core_clk) disable iff (!rst_n) // R10
        doInit |=> (status1 == $past(set1)) && (status2 == $past(set2)))
        else $error("initialize did not restore status defaults");

    a_stat2_clears: assert property (@(posedge core_clk) disable iff (!rst_n) // R17
        (rdStat2 && !doInit) |=> status2 == $past(set2))
        else $error("status 2 read did not clear returned bits");

    // Without a read or a bit 7 write a flag may only be added, never dropped
    a_flag_sticky: assert property (@(posedge core_clk) disable iff (!rst_n) // R11
        (!rdStat1 && !doInit) |=> (status1 & $past(status1)) == $past(status1))
        else $error("status 1 flag lost without a read");

    a_ovt_latch: assert property (@(posedge core_clk) disable iff (!rst_n) // R21
        (overtempEvent && st.cfg.ovtEnable) |=> st.ovtLatched)
        else $error("enabled over-temperature event not latched");

    a_ovt_disabled: assert property (@(posedge core_clk) disable iff (!rst_n) // R21
        !st.cfg.ovtEnable |=> !overtempOe)
        else $error("over-temperature output driven while disabled");

    a_ovt_pin_flag: assert property (@(posedge core_clk) disable iff (!rst_n) // R15
        (!overtempIn && !overtempOe) |=> status2[`MCIS_S2_OVT_PIN])
        else $error("external over-temperature pull not flagged");

    a_pulse_ends: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
        $fell(pulseBusy) |=> resetOutN)
        else $error("reset output stayed low after pulse");

    a_cfg_busy_bit: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
        (regRd && regAddr == `MCIS_ADDR_CFG) |=> regRdData[`MCIS_BIT_RST_REQ] == $past(pulseBusy))
        else $error("reset request bit does not show pulse state");

    a_diode_flags: assert property (@(posedge core_clk) disable iff (!rst_n) // R16
        (|events.diodeFault) |=> ((status2[7:6] & $past(events.diodeFault)) == $past(events.diodeFault)))
        else $error("diode fault not flagged");

    a_limit2_flags: assert property (@(posedge core_clk) disable iff (!rst_n) // R13
        (monitorActive && |events.limit2) |=> ((status2[1:0] & $past(events.limit2)) == $past(events.limit2)))
        else $error("status 2 limit violation not flagged");

    a_temp_flags: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
        (monitorActive && |events.tempEvt)
        |=> ((status1[`MCIS_S1_TEMP_REM:`MCIS_S1_TEMP_INT] & $past(events.tempEvt)) == $past(events.tempEvt)))
        else $error("temperature event not flagged");
endmodule

//--- testbench.sv
// Self-checking testbench of the monitor control block
`timescale 1ns/100ps
`include "mcis_cfg.svh"
module testbench;
    localparam int PULSE = 16;
    logic core_clk, rst_n, regWr, regRd, chassisOpen, overtempEvent, extLow;
    logic [7:0] regAddr, regWrData, regRdData;
    logic overtempIn, overtempOut, overtempOe, irqOutN, resetOutN, monitorActive;
    mcis_pkg::mcis_events_t ev;
    logic [7:0] expQ[$];
    int nMismatch = 0;
    int nTests = 0;
    // Open-drain wire with pull-up, also pulled low by an outside source
    assign overtempIn = (overtempOe ? overtempOut : 1'b1) & ~extLow;
    mcis_top #(.RST_PULSE_CYCLES(PULSE)) u_mcis_top (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWr(regWr), .regRd(regRd), .regWrData(regWrData), .regRdData(regRdData), .events(ev),
        .chassisOpen(chassisOpen), .overtempEvent(overtempEvent), .overtempIn(overtempIn),
        .overtempOut(overtempOut), .overtempOe(overtempOe), .irqOutN(irqOutN), .resetOutN(resetOutN),
        .monitorActive(monitorActive));
    mcis_host_model u_mcis_host_model (.core_clk(core_clk), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
        .regWrData(regWrData), .regRdData(regRdData));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        nTests++;
        if (seen !== exp) begin
            nMismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic completeRun();
        if (nMismatch == 0 && nTests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic rdExp(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        u_mcis_host_model.rd(a);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_mcis_host_model.wr(a, d);
    endtask
    task automatic pin(input string name, input logic seen, input logic exp);
        check(name, {7'h00, seen}, {7'h00, exp});
    endtask
    task automatic settle();
        repeat (3) @(negedge core_clk);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #200_000;
        nMismatch++;
        completeRun();
    end
    initial forever begin
        @(u_mcis_host_model.rdEv);
        check("regRdData", u_mcis_host_model.rdData, expQ.pop_front());
    end
    initial begin
        logic [7:0] m, v, s1;
        logic [1:0] t;
        int n;
        rst_n = 1'b0;
        ev = '0;
        chassisOpen = 1'b0;
        overtempEvent = 1'b0;
        extLow = 1'b0;
        void'($urandom(32'h74c6_99d3));
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        rdExp(`MCIS_ADDR_CFG, `MCIS_CFG_RESET);
        rdExp(`MCIS_ADDR_STAT1, 8'h00);
        rdExp(`MCIS_ADDR_STAT2, 8'h00);
        rdExp(`MCIS_ADDR_MASK1, 8'h00);
        rdExp(8'h50, 8'h00);
        pin("irqOutN", irqOutN, 1'b1);
        pin("monitorActive", monitorActive, 1'b0);
        for (int i = 0; i < 6; i++) begin
            m = 8'($urandom);
            v = 8'($urandom);
            t = 2'($urandom);
            s1 = v | {2'b00, t, 4'h0};
            wr(`MCIS_ADDR_MASK1, m);
            wr(`MCIS_ADDR_CFG, 8'h23);
            ev.limit1 = v;
            ev.tempEvt = t;
            // Held two cycles so the cause overlaps the run enable
            repeat (2) @(negedge core_clk);
            ev = '0;
            settle();
            pin("monitorActive", monitorActive, 1'b1);
            pin("irqOutN", irqOutN, ~|(s1 & ~m));
            if (i % 3 == 1) begin
                wr(`MCIS_ADDR_CFG, 8'h22);
                settle();
                pin("irqOutN", irqOutN, ~|(s1 & ~m));
            end
            if (i % 3 == 2) begin
                wr(`MCIS_ADDR_CFG, 8'h2b);
                settle();
                pin("irqOutN", irqOutN, 1'b1);
                pin("monitorActive", monitorActive, 1'b0);
            end
            rdExp(`MCIS_ADDR_STAT1, s1);
            rdExp(`MCIS_ADDR_STAT1, 8'h00);
            settle();
            pin("irqOutN", irqOutN, 1'b1);
        end
        wr(`MCIS_ADDR_MASK1, 8'h00);
        wr(`MCIS_ADDR_CFG, 8'h23);
        ev.limit1 = 8'h01;
        settle();
        rdExp(`MCIS_ADDR_STAT1, 8'h01);
        rdExp(`MCIS_ADDR_STAT1, 8'h01);
        ev = '0;
        rdExp(`MCIS_ADDR_STAT1, 8'h01);
        rdExp(`MCIS_ADDR_STAT1, 8'h00);
        wr(`MCIS_ADDR_CFG, 8'h21);
        chassisOpen = 1'b1;
        @(negedge core_clk);
        chassisOpen = 1'b0;
        settle();
        pin("irqOutN", irqOutN, 1'b1);
        wr(`MCIS_ADDR_CFG, 8'h23);
        settle();
        pin("irqOutN", irqOutN, 1'b0);
        rdExp(`MCIS_ADDR_STAT2, 8'h10);
        ev.limit2 = 2'b11;
        ev.diodeFault = 2'b11;
        chassisOpen = 1'b1;
        extLow = 1'b1;
        repeat (2) @(negedge core_clk);
        ev = '0;
        chassisOpen = 1'b0;
        extLow = 1'b0;
        settle();
        pin("irqOutN", irqOutN, 1'b0);
        rdExp(`MCIS_ADDR_STAT2, 8'hf3);
        rdExp(`MCIS_ADDR_STAT2, 8'h00);
        wr(`MCIS_ADDR_CFG, 8'h27);
        overtempEvent = 1'b1;
        @(negedge core_clk);
        overtempEvent = 1'b0;
        settle();
        pin("overtempOe", overtempOe, 1'b1);
        pin("overtempIn", overtempIn, 1'b0);
        wr(`MCIS_ADDR_CFG, 8'h67);
        settle();
        pin("overtempOe", overtempOe, 1'b0);
        rdExp(`MCIS_ADDR_STAT2, 8'h00);
        rdExp(`MCIS_ADDR_CFG, 8'h27);
        wr(`MCIS_ADDR_CFG, 8'h10);
        n = 0;
        repeat (PULSE + 20) begin
            @(negedge core_clk);
            if (resetOutN === 1'b0) n++;
        end
        check("resetOutN low cycles", 8'(n), 8'(PULSE));
        rdExp(`MCIS_ADDR_CFG, 8'h00);
        overtempEvent = 1'b1;
        @(negedge core_clk);
        overtempEvent = 1'b0;
        settle();
        pin("overtempOe", overtempOe, 1'b0);
        wr(`MCIS_ADDR_MASK1, 8'h5a);
        wr(`MCIS_ADDR_CFG, 8'h83);
        rdExp(`MCIS_ADDR_CFG, `MCIS_CFG_RESET);
        rdExp(`MCIS_ADDR_MASK1, 8'h00);
        settle();
        completeRun();
    end
endmodule
